// [emb_block.sv]
// Our own choices: the register offsets and the APB interface to the registers.
`timescale 1ns/1ps
// Overview of operation
// - the block holds 2,048 bits and works as RAM, ROM, dual-port RAM or FIFO.
// - as RAM it is organised as 256x8, 512x4, 1,024x2 or 2,048x1 by a select field.
// - user-logic writes use an internal strobe made from the input-side clock event.
// - contents may be loaded with a fixed pattern so the block acts as a lookup table.
// - one block can hold a 4x4 multiplier table, eight address bits to eight product bits.
// - input and output sides take independent clock events.
// - data input, output and address-plus-strobe paths each have an optional register.
// - write enable comes from a global signal or from local routing driven by user logic.
// - each block clock selects a global signal, a dedicated clock pin or local routing.
// - blocks placed side by side on shared addresses form wider memories.
// - blocks cascade in depth by address match with no extra access delay.
// - each output bit may drive up to two row and two column channels; idle rows pass through.
// - six dedicated low-skew inputs, four of which feed global signals internal logic may drive.
// - one block sits in each row and is fed from that row's routing.
module emb_block #(
  parameter int BITS = emb_pkg::MEM_BITS
) (
  // clock and reset
  input  wire logic                           sys_clk,
  input  wire logic                           rst,
  // apb slave
  input  wire logic [emb_pkg::APB_AW-1:0]     paddr,
  input  wire logic                           psel,
  input  wire logic                           penable,
  input  wire logic                           pwrite,
  input  wire logic [31:0]                    pwdata,
  output logic      [31:0]                    prdata,
  output logic                                pready,
  output logic                                pslverr,
  // dedicated inputs and internal global drive
  input  wire logic [emb_pkg::N_DED-1:0]      dedIn,
  input  wire logic [emb_pkg::N_GLOBAL-1:0]   globalDrive,
  // row routing in
  input  wire logic [emb_pkg::ADDR_W-1:0]     rowAddr,
  input  wire logic [emb_pkg::HI_W-1:0]       rowAddrHi,
  input  wire logic [emb_pkg::ADDR_W-1:0]     rowRdAddr,
  input  wire logic [emb_pkg::DATA_W-1:0]     rowData,
  input  wire logic                           rowWe,
  input  wire logic                           rowRdReq,
  input  wire logic                           localClkIn,
  input  wire logic                           localClkOut,
  // cascade and channels
  input  wire logic [emb_pkg::DATA_W-1:0]     cascadeIn,
  input  wire logic [emb_pkg::DATA_W*2-1:0]   rowChanIn,
  output logic      [emb_pkg::DATA_W-1:0]     blockData,
  output logic      [emb_pkg::DATA_W*2-1:0]   rowChan,
  output logic      [emb_pkg::DATA_W*2-1:0]   colChan,
  output logic      [emb_pkg::N_GLOBAL-1:0]   globalSig,
  output logic                                fifoFull,
  output logic                                fifoEmpty
);
  import emb_pkg::*;

  // ****************************************
  // declarations
  // ****************************************
  emb_mem_if mem ();

  logic [31:0]        ctrlReg;
  logic [31:0]        routeReg;
  logic [ADDR_W-1:0]  swAddrReg;
  emb_load_e          ldReg;
  logic [7:0]         ldCntReg;
  emb_mode_e          mode;
  logic [1:0]         wSel;
  logic [N_DED-1:0]   dedLevel;
  logic [7:0]         inSrc;
  logic [7:0]         outSrc;
  logic [7:0]         inPrevReg;
  logic [7:0]         outPrevReg;
  logic               inTick;
  logic               outTick;
  logic               regClr;
  logic [ADDR_W-1:0]  addrReg;
  logic [ADDR_W-1:0]  rdAddrReg;
  logic [HI_W-1:0]    hiReg;
  logic               weReg;
  logic [DATA_W-1:0]  dataReg;
  logic [ADDR_W-1:0]  addrEff;
  logic [ADDR_W-1:0]  rdAddrEff;
  logic [HI_W-1:0]    hiEff;
  logic               weEff;
  logic [DATA_W-1:0]  dataEff;
  logic               weRaw;
  logic               hit;
  logic               weStrobe;
  logic               isFifo;
  logic [ADDR_W-1:0]  wPtrReg;
  logic [ADDR_W-1:0]  rPtrReg;
  logic [11:0]        fifoCntReg;
  logic [11:0]        depth;
  logic               push;
  logic               pop;
  logic [DATA_W-1:0]  outReg;
  logic               hitReg;
  logic               apbAcc;
  logic               apbWr;
  logic               mapped;
  logic [31:0]        rdMux;
  logic               dataWr;

  assign mode   = emb_mode_e'(ctrlReg[CTL_MODE +: 2]);
  assign wSel   = ctrlReg[CTL_WSEL +: 2];
  assign isFifo = (mode == MODE_FIFO);

  // ****************************************
  // dedicated inputs and global signals
  // ****************************************
  emb_pin_sync #(
    .WIDTH (N_DED)
  ) uDedSync (
    .sys_clk  (sys_clk),
    .rst      (rst),
    .pinIn    (dedIn),
    .pinLevel (dedLevel)
  );

  assign globalSig = dedLevel[N_GLOBAL-1:0] | globalDrive;

  // ****************************************
  // clock event selection
  // ****************************************
  // the top source is a constant high whose previous value stays low,
  // so selecting it gives a tick on every cycle
  assign inSrc  = {1'b1, localClkIn, dedLevel[N_DED-1:N_GLOBAL], globalSig};
  assign outSrc = {1'b1, localClkOut, dedLevel[N_DED-1:N_GLOBAL], globalSig};

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      inPrevReg  <= '0;
      outPrevReg <= '0;
    end else begin
      inPrevReg  <= {1'b0, inSrc[6:0]};
      outPrevReg <= {1'b0, outSrc[6:0]};
    end
  end

  assign inTick  = inSrc[ctrlReg[CTL_INCLK +: 3]] & ~inPrevReg[ctrlReg[CTL_INCLK +: 3]];
  assign outTick = outSrc[ctrlReg[CTL_OUTCLK +: 3]] & ~outPrevReg[ctrlReg[CTL_OUTCLK +: 3]];
  assign regClr  = ctrlReg[CTL_CLREN] & globalSig[ctrlReg[CTL_CLRSEL +: 2]];

  // ****************************************
  // input side
  // ****************************************
  assign weRaw = ctrlReg[CTL_WESRC] ? rowWe : globalSig[ctrlReg[CTL_WEGSEL +: 2]];

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      addrReg   <= '0;
      rdAddrReg <= '0;
      hiReg     <= '0;
      weReg     <= 1'b0;
    end else if (regClr) begin
      addrReg   <= '0;
      rdAddrReg <= '0;
      hiReg     <= '0;
      weReg     <= 1'b0;
    end else if (inTick) begin
      addrReg   <= rowAddr;
      rdAddrReg <= rowRdAddr;
      hiReg     <= rowAddrHi;
      weReg     <= weRaw;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      dataReg <= '0;
    end else if (regClr) begin
      dataReg <= '0;
    end else if (inTick) begin
      dataReg <= rowData;
    end
  end

  assign addrEff   = ctrlReg[CTL_ADREG] ? addrReg : rowAddr;
  assign rdAddrEff = ctrlReg[CTL_ADREG] ? rdAddrReg : rowRdAddr;
  assign hiEff     = ctrlReg[CTL_ADREG] ? hiReg : rowAddrHi;
  assign weEff     = ctrlReg[CTL_ADREG] ? weReg : weRaw;
  assign dataEff   = ctrlReg[CTL_INREG] ? dataReg : rowData;

  // width expansion shares addresses; depth expansion decodes the high bits
  assign hit = (hiEff == ctrlReg[CTL_BLKSEL +: HI_W]);

  // strobe exists only for the one cycle of the input clock event
  assign weStrobe = inTick & weEff & hit & (mode != MODE_ROM)
                  & ~(isFifo & fifoFull);

  // ****************************************
  // fifo pointers
  // ****************************************
  assign depth     = DEPTH_X8 << wSel;
  assign fifoFull  = (fifoCntReg == depth);
  assign fifoEmpty = (fifoCntReg == '0);
  assign push      = isFifo & weStrobe;
  assign pop       = isFifo & outTick & rowRdReq & ~fifoEmpty;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      wPtrReg    <= '0;
      rPtrReg    <= '0;
      fifoCntReg <= '0;
    end else if (!isFifo) begin
      wPtrReg    <= '0;
      rPtrReg    <= '0;
      fifoCntReg <= '0;
    end else begin
      if (push) begin
        wPtrReg <= (12'(wPtrReg) == depth - 12'h001) ? '0 : wPtrReg + 1'b1;
      end
      if (pop) begin
        rPtrReg <= (12'(rPtrReg) == depth - 12'h001) ? '0 : rPtrReg + 1'b1;
      end
      if (push && !pop) begin
        fifoCntReg <= fifoCntReg + 12'h001;
      end else if (pop && !push) begin
        fifoCntReg <= fifoCntReg - 12'h001;
      end
    end
  end

  // ****************************************
  // array write arbitration
  // ****************************************
  // table loader beats software, software beats user logic in one cycle
  always_comb begin
    mem.we    = weStrobe;
    mem.wAddr = isFifo ? wPtrReg : addrEff;
    mem.wData = dataEff;
    mem.wSel  = wSel;
    if (ldReg == LD_RUN) begin
      mem.we    = 1'b1;
      mem.wAddr = ADDR_W'(ldCntReg);
      mem.wData = {4'h0, ldCntReg[7:4]} * {4'h0, ldCntReg[3:0]};
      mem.wSel  = WSEL_X8;
    end else if (dataWr) begin
      mem.we    = 1'b1;
      mem.wAddr = swAddrReg;
      mem.wData = pwdata[DATA_W-1:0];
    end
  end

  assign mem.rAddr = isFifo ? rPtrReg :
                     ((mode == MODE_DPRAM) ? rdAddrEff : addrEff);
  assign mem.rSel  = wSel;
  assign mem.sAddr = swAddrReg;
  assign mem.sSel  = wSel;

  emb_store #(
    .BITS (BITS)
  ) uStore (
    .sys_clk (sys_clk),
    .mem     (mem.store)
  );

  // ****************************************
  // output side
  // ****************************************
  // read data is sampled before the same-edge write lands
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      outReg <= '0;
      hitReg <= 1'b0;
    end else if (regClr) begin
      outReg <= '0;
      hitReg <= 1'b0;
    end else if (isFifo) begin
      if (pop) begin
        outReg <= mem.rData;
        hitReg <= 1'b1;
      end
    end else if (!ctrlReg[CTL_OUTREG] || outTick) begin
      outReg <= mem.rData;
      hitReg <= hit;
    end
  end

  // cascade pass-through adds no register stage
  assign blockData = hitReg ? outReg : cascadeIn;

  genvar g;
  genvar c;
  for (g = 0; g < DATA_W; g++) begin : gBit
    for (c = 0; c < N_CHAN; c++) begin : gChan
      assign rowChan[g*N_CHAN+c] = routeReg[g*4+c] ? blockData[g]
                                 : rowChanIn[g*N_CHAN+c];
      assign colChan[g*N_CHAN+c] = routeReg[g*4+N_CHAN+c] & blockData[g];
    end
  end

  // ****************************************
  // table loader
  // ****************************************
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ldReg    <= LD_IDLE;
      ldCntReg <= '0;
    end else begin
      case (ldReg)
        LD_IDLE: begin
          if (apbWr && paddr == OFF_TABLE && pwdata[0]) begin
            ldReg    <= LD_RUN;
            ldCntReg <= '0;
          end
        end
        LD_RUN: begin
          ldCntReg <= ldCntReg + 8'h01;
          if (ldCntReg == LD_LAST) begin
            ldReg <= LD_IDLE;
          end
        end
        default: ldReg <= LD_IDLE;
      endcase
    end
  end

  // ****************************************
  // apb slave
  // ****************************************
  assign apbAcc  = psel & penable;
  assign apbWr   = apbAcc & pwrite & mapped;
  assign dataWr  = apbWr & (paddr == OFF_DATA) & (ldReg == LD_IDLE);
  assign pready  = 1'b1;
  assign pslverr = apbAcc & ~mapped;

  always_comb begin
    mapped = 1'b1;
    rdMux  = '0;
    case (paddr)
      OFF_CTRL:   rdMux = ctrlReg;
      OFF_SWADDR: rdMux = {21'h0, swAddrReg};
      OFF_DATA:   rdMux = {24'h0, mem.sData};
      OFF_STAT: begin
        rdMux                = {20'h0, fifoCntReg};
        rdMux[STAT_EMPTY]    = fifoEmpty;
        rdMux[STAT_FULL]     = fifoFull;
        rdMux[STAT_BUSY]     = (ldReg == LD_RUN);
      end
      OFF_ROUTE:  rdMux = routeReg;
      OFF_TABLE:  rdMux = {31'h0, (ldReg == LD_RUN)};
      default:    mapped = 1'b0;
    endcase
  end

  // read data is captured in the setup cycle, valid all access phase
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      prdata <= '0;
    end else if (psel && !penable && !pwrite) begin
      prdata <= rdMux;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ctrlReg  <= CTRL_RESET;
      routeReg <= ROUTE_RESET;
    end else if (apbWr && paddr == OFF_CTRL) begin
      ctrlReg  <= pwdata & CTRL_MASK;
    end else if (apbWr && paddr == OFF_ROUTE) begin
      routeReg <= pwdata;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      swAddrReg <= '0;
    end else if (apbWr && paddr == OFF_SWADDR) begin
      swAddrReg <= pwdata[ADDR_W-1:0];
    end else if (dataWr) begin
      swAddrReg <= swAddrReg + 1'b1;
    end
  end
endmodule : emb_block

// [emb_pkg.sv]
package emb_pkg;

  // ****************************************
  // sizes
  // ****************************************
  localparam int MEM_BITS = 2048;
  localparam int ADDR_W   = 11;
  localparam int DATA_W   = 8;
  localparam int HI_W     = 4;
  localparam int N_DED    = 6;
  localparam int N_GLOBAL = 4;
  localparam int N_CHAN   = 2;
  localparam int APB_AW   = 8;

  // ****************************************
  // register offsets
  // ****************************************
  localparam logic [APB_AW-1:0] OFF_CTRL   = 8'h00;
  localparam logic [APB_AW-1:0] OFF_SWADDR = 8'h04;
  localparam logic [APB_AW-1:0] OFF_DATA   = 8'h08;
  localparam logic [APB_AW-1:0] OFF_STAT   = 8'h0C;
  localparam logic [APB_AW-1:0] OFF_ROUTE  = 8'h10;
  localparam logic [APB_AW-1:0] OFF_TABLE  = 8'h14;

  // ****************************************
  // control and status fields
  // ****************************************
  localparam int CTL_MODE   = 0;
  localparam int CTL_WSEL   = 2;
  localparam int CTL_INREG  = 4;
  localparam int CTL_OUTREG = 5;
  localparam int CTL_ADREG  = 6;
  localparam int CTL_WESRC  = 7;
  localparam int CTL_WEGSEL = 8;
  localparam int CTL_INCLK  = 10;
  localparam int CTL_OUTCLK = 13;
  localparam int CTL_CLRSEL = 16;
  localparam int CTL_CLREN  = 18;
  localparam int CTL_BLKSEL = 20;
  localparam int STAT_EMPTY = 12;
  localparam int STAT_FULL  = 13;
  localparam int STAT_BUSY  = 14;

  localparam logic [31:0] CTRL_MASK   = 32'h00F7_FFFF;
  localparam logic [31:0] CTRL_RESET  = 32'h0000_FC00;
  localparam logic [31:0] ROUTE_RESET = 32'h0000_0000;

  localparam logic [11:0] DEPTH_X8 = 12'h100;
  localparam logic [3:0]  BITS_X8  = 4'h8;
  localparam logic [1:0]  WSEL_X8  = 2'h0;
  localparam logic [1:0]  SHIFT_X8 = 2'h3;
  localparam logic [2:0]  CK_FREE  = 3'h7;
  localparam logic [7:0]  LD_LAST  = 8'hFF;

  typedef enum logic [1:0] {
    MODE_RAM   = 2'b00,
    MODE_ROM   = 2'b01,
    MODE_DPRAM = 2'b10,
    MODE_FIFO  = 2'b11
  } emb_mode_e;

  typedef enum logic {
    LD_IDLE = 1'b0,
    LD_RUN  = 1'b1
  } emb_load_e;

endpackage : emb_pkg

// [emb_mem_if.sv]
`timescale 1ns/1ps
interface emb_mem_if;
  logic                       we;
  logic [emb_pkg::ADDR_W-1:0] wAddr;
  logic [emb_pkg::DATA_W-1:0] wData;
  logic [1:0]                 wSel;
  logic [emb_pkg::ADDR_W-1:0] rAddr;
  logic [1:0]                 rSel;
  logic [emb_pkg::DATA_W-1:0] rData;
  logic [emb_pkg::ADDR_W-1:0] sAddr;
  logic [1:0]                 sSel;
  logic [emb_pkg::DATA_W-1:0] sData;

  modport store (
    input  we, wAddr, wData, wSel, rAddr, rSel, sAddr, sSel,
    output rData, sData
  );
  modport ctrl (
    output we, wAddr, wData, wSel, rAddr, rSel, sAddr, sSel,
    input  rData, sData
  );
endinterface : emb_mem_if

// [emb_pin_sync.sv]
`timescale 1ns/1ps
module emb_pin_sync #(
  parameter int WIDTH = emb_pkg::N_DED
) (
  // clock and reset
  input  wire logic             sys_clk,
  input  wire logic             rst,
  // pins and clean levels
  input  wire logic [WIDTH-1:0] pinIn,
  output logic      [WIDTH-1:0] pinLevel
);
  import emb_pkg::*;

  logic [WIDTH-1:0] stage1Reg;
  logic [WIDTH-1:0] stage2Reg;
  logic [WIDTH-1:0] stage3Reg;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      stage1Reg <= '0;
      stage2Reg <= '0;
      stage3Reg <= '0;
    end else begin
      stage1Reg <= pinIn;
      stage2Reg <= stage1Reg;
      stage3Reg <= stage2Reg;
    end
  end

  // a change counts only once stages two and three agree
  genvar g;
  for (g = 0; g < WIDTH; g++) begin : gLevel
    always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
        pinLevel[g] <= 1'b0;
      end else if (stage2Reg[g] == stage3Reg[g]) begin
        pinLevel[g] <= stage3Reg[g];
      end
    end
  end
endmodule : emb_pin_sync

// [emb_store.sv]
`timescale 1ns/1ps
module emb_store #(
  parameter int BITS = emb_pkg::MEM_BITS
) (
  // clock
  input wire logic sys_clk,
  // array ports
  emb_mem_if.store mem
);
  import emb_pkg::*;

  // no reset: contents survive every clear
  logic [BITS-1:0]   memBits;
  logic [ADDR_W-1:0] wBase;
  logic [ADDR_W-1:0] rBase;
  logic [ADDR_W-1:0] sBase;
  logic [3:0]        wBits;
  logic [3:0]        rBits;
  logic [3:0]        sBits;

  assign wBase = ADDR_W'(mem.wAddr << (SHIFT_X8 - mem.wSel));
  assign rBase = ADDR_W'(mem.rAddr << (SHIFT_X8 - mem.rSel));
  assign sBase = ADDR_W'(mem.sAddr << (SHIFT_X8 - mem.sSel));
  assign wBits = BITS_X8 >> mem.wSel;
  assign rBits = BITS_X8 >> mem.rSel;
  assign sBits = BITS_X8 >> mem.sSel;

  always_ff @(posedge sys_clk) begin
    if (mem.we) begin
      for (int i = 0; i < DATA_W; i++) begin
        if (4'(i) < wBits) begin
          memBits[ADDR_W'(wBase + ADDR_W'(i))] <= mem.wData[i];
        end
      end
    end
  end

  // reads see the array before this edge's write
  always_comb begin
    mem.rData = '0;
    mem.sData = '0;
    for (int i = 0; i < DATA_W; i++) begin
      if (4'(i) < rBits) begin
        mem.rData[i] = memBits[ADDR_W'(rBase + ADDR_W'(i))];
      end
      if (4'(i) < sBits) begin
        mem.sData[i] = memBits[ADDR_W'(sBase + ADDR_W'(i))];
      end
    end
  end
endmodule : emb_store

// [emb_block_monitor.sv]
`timescale 1ns/1ps
module emb_block_monitor (
  // clock and reset
  input wire logic        sys_clk,
  input wire logic        rst,
  // apb
  input wire logic [7:0]  paddr,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] prdata,
  input wire logic        pslverr,
  // globals
  input wire logic [5:0]  dedIn,
  input wire logic [3:0]  globalDrive,
  input wire logic [3:0]  globalSig,
  // data and channels
  input wire logic [7:0]  blockData,
  input wire logic [15:0] rowChanIn,
  input wire logic [15:0] rowChan,
  input wire logic [15:0] colChan,
  input wire logic        fifoFull,
  input wire logic        fifoEmpty
);
  import emb_pkg::*;
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);

  // ****
  // helpers
  // ****
  // each data bit owns two neighbouring channels
  logic [15:0] fan;
  always_comb begin
    for (int i = 0; i < 16; i++) begin
      fan[i] = blockData[i / 2];
    end
  end
  sequence rd_setup;
    psel && !penable && !pwrite;
  endsequence
  sequence bad_read;
    rd_setup ##0 (paddr > OFF_TABLE);
  endsequence

  // ****
  // checks
  // ****
  a_bad_slverr: assert property (psel && penable && paddr > OFF_TABLE |-> pslverr)
    else $error("unmapped access without slverr");
  a_bad_rdata: assert property (bad_read |=> prdata == 32'h0)
    else $error("unmapped read gave data");
  a_rdata_hold: assert property ($changed(prdata) |-> $past(psel) && !$past(penable)
    && !$past(pwrite))
    else $error("prdata moved outside read setup");
  a_global_or: assert property ((globalSig & globalDrive) == globalDrive)
    else $error("internal drive lost");
  a_global_sync: assert property (
    (globalDrive == 4'h0 && $stable(dedIn)) [*5] |-> globalSig == dedIn[3:0])
    else $error("dedicated input not on global");
  a_row_chan: assert property (((rowChan ^ rowChanIn) & (rowChan ^ fan)) == 16'h0)
    else $error("row channel source wrong");
  a_col_gate: assert property ((colChan & ~fan) == 16'h0)
    else $error("column channel without data");
  a_reset_empty: assert property ($fell(rst) |-> fifoEmpty && !fifoFull)
    else $error("fifo flags wrong after reset");
endmodule : emb_block_monitor

bind emb_block emb_block_monitor emb_block_monitor_inst (
  .sys_clk, .rst, .paddr, .psel, .penable, .pwrite, .prdata, .pslverr, .dedIn,
  .globalDrive, .globalSig, .blockData, .rowChanIn, .rowChan, .colChan, .fifoFull,
  .fifoEmpty
);

// [emb_user_model.sv]
`timescale 1ns/1ps
module emb_user_model (
  // clock
  input  wire logic        sys_clk,
  // row routing from user logic
  output logic      [10:0] rowAddr,
  output logic      [7:0]  rowData,
  output logic             rowWe,
  output logic             localClkIn
);
  // ****
  // row access
  // ****
  initial begin
    rowAddr = '0;
    rowData = '0;
    rowWe = 1'b0;
    localClkIn = 1'b0;
  end
  // held three edges: a local clock event lands a cycle after its level
  task automatic drive(input logic [10:0] a, input logic [7:0] d, input logic we,
                       input logic lk);
    @(posedge sys_clk);
    rowAddr <= a;
    rowData <= d;
    rowWe <= we;
    localClkIn <= lk;
    repeat (3) @(posedge sys_clk);
    rowWe <= 1'b0;
    localClkIn <= 1'b0;
    // released lines show no stale word
    rowData <= ~d;
  endtask : drive
endmodule : emb_user_model

// [tb_top.sv]
`timescale 1ns/1ps
module tb_top;
  import emb_pkg::*;
  // ****
  // hookup
  // ****
  logic        sys_clk;
  logic        rst = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = '0;
  logic [31:0] pwdata = '0;
  logic [5:0]  dedIn = '0;
  logic [3:0]  globalDrive = '0;
  logic [3:0]  rowAddrHi = '0;
  logic [10:0] rowRdAddr = '0;
  logic [7:0]  cascadeIn = '0;
  logic [15:0] rowChanIn = '0;
  logic        rowRdReq = 1'b0;
  logic [31:0] prdata, rd;
  logic [10:0] rowAddr;
  logic [7:0]  rowData, blockData, d, c;
  logic [15:0] rowChan, colChan, xr, xc;
  logic [3:0]  globalSig;
  logic        pready, pslverr, rowWe, localClkIn, fifoFull, fifoEmpty, er;
  int          num_errors = 0;
  int          check_count = 0;
  int          a, b;
  int          q[$];
  logic [7:0]  mem [256];

  emb_block emb_block_inst (
    .sys_clk, .rst, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready,
    .pslverr, .dedIn, .globalDrive, .rowAddr, .rowAddrHi, .rowRdAddr, .rowData,
    .rowWe, .rowRdReq, .localClkIn, .localClkOut(1'b0), .cascadeIn,
    .rowChanIn, .blockData, .rowChan, .colChan, .globalSig, .fifoFull, .fifoEmpty
  );
  emb_user_model emb_user_model_inst (.sys_clk, .rowAddr, .rowData, .rowWe, .localClkIn);

  // ****
  // tasks
  // ****
  task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
    check_count++;
    if (got !== ex) begin
      $display("ERROR %s expected %h seen %h", nm, ex, got);
      num_errors++;
    end
  endtask : chk

  task automatic apb(input logic wr, input logic [7:0] ad, input logic [31:0] wd);
    @(posedge sys_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= ad;
    pwdata <= wd;
    @(posedge sys_clk);
    penable <= 1'b1;
    @(posedge sys_clk);
    // only the watchdog ends a wait for the answer
    while (pready !== 1'b1) begin
      @(posedge sys_clk);
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rdmem(input int ad, input logic [7:0] ex);
    apb(1'b1, OFF_SWADDR, ad);
    apb(1'b0, OFF_DATA, '0);
    chk("memword", ex, rd[7:0]);
  endtask : rdmem

  task automatic row(input int ad, input logic [7:0] dv, input logic we, input logic lk);
    emb_user_model_inst.drive(ad[10:0], dv, we, lk);
    #1;
  endtask : row

  task automatic close_out();
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : close_out

  // ****
  // clock, watchdog, tests
  // ****
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end
  // whole run is a few hundred cycles
  initial begin
    repeat (20000) @(posedge sys_clk);
    num_errors++;
    close_out();
  end
  initial begin
    void'($urandom(32'hC73B));
    repeat (10) @(posedge sys_clk);
    rst <= 1'b0;
    dedIn <= 6'h3E & 6'($urandom);
    apb(1'b0, OFF_CTRL, '0);
    chk("ctrl", CTRL_RESET, rd);
    apb(1'b0, OFF_STAT, '0);
    chk("empty", 1, rd[STAT_EMPTY]);
    apb(1'b0, 8'h40, '0);
    chk("slverr", 1, er);
    chk("badread", 0, rd);
    apb(1'b1, OFF_CTRL, 32'h0000_FC80);
    repeat (8) begin
      a = $urandom % 256;
      d = $urandom;
      mem[a] = d;
      q.push_back(a);
      row(a, d, 1'b1, 1'b0);
      chk("rowread", d, blockData);
    end
    foreach (q[i]) begin
      rdmem(q[i], mem[q[i]]);
    end
    a = $urandom % 255;
    d = $urandom;
    apb(1'b1, OFF_SWADDR, a);
    apb(1'b1, OFF_DATA, {24'h0, d});
    apb(1'b0, OFF_SWADDR, '0);
    chk("swaddr", a + 1, rd);
    row(a, 8'h00, 1'b0, 1'b0);
    chk("apbwrite", d, blockData);
    b = $urandom;
    @(posedge sys_clk);
    rowChanIn <= 16'($urandom);
    apb(1'b1, OFF_ROUTE, b);
    @(posedge sys_clk);
    #1;
    for (int i = 0; i < 16; i++) begin
      xr[i] = b[4 * (i / 2) + i % 2] ? d[i / 2] : rowChanIn[i];
      xc[i] = b[4 * (i / 2) + 2 + i % 2] & d[i / 2];
    end
    chk("rowchan", xr, rowChan);
    chk("colchan", xc, colChan);
    apb(1'b1, OFF_CTRL, 32'h0050_FC80);
    c = $urandom;
    cascadeIn <= c;
    rowAddrHi <= 4'h3;
    row(a, ~d, 1'b1, 1'b0);
    chk("cascade", c, blockData);
    @(posedge sys_clk);
    rowAddrHi <= 4'h5;
    row(a, 8'h00, 1'b0, 1'b0);
    chk("cascadehit", d, blockData);
    @(posedge sys_clk);
    rowAddrHi <= 4'h0;
    apb(1'b1, OFF_CTRL, 32'h0000_FC82);
    rowRdAddr <= a[10:0];
    fork
      row(a, ~d, 1'b1, 1'b0);
      begin
        repeat (2) @(posedge sys_clk);
        #1;
        chk("dpold", d, blockData);
      end
    join
    d = ~d;
    chk("dpnew", d, blockData);
    apb(1'b1, OFF_CTRL, 32'h0000_F880);
    row(a, ~d, 1'b1, 1'b0);
    rdmem(a, d);
    row(a, ~d, 1'b1, 1'b1);
    d = ~d;
    rdmem(a, d);
    apb(1'b1, OFF_CTRL, 32'h0004_FC80);
    globalDrive <= 4'h1;
    apb(1'b0, OFF_STAT, '0);
    globalDrive <= 4'h0;
    rdmem(a, d);
    // output register clocked by an idle local clock must hold its word
    apb(1'b1, OFF_CTRL, 32'h0000_DCA0);
    row(a, ~d, 1'b1, 1'b0);
    chk("outreg", d, blockData);
    rdmem(a, ~d);
    for (int w = 1; w < 4; w++) begin
      apb(1'b1, OFF_CTRL, 32'h0000_FC80 | (w << CTL_WSEL));
      a = $urandom % (256 << w);
      c = $urandom;
      b = (1 << (8 >> w)) - 1;
      row(a, c, 1'b1, 1'b0);
      row(a ^ 1, ~c, 1'b1, 1'b0);
      row(a, 8'h00, 1'b0, 1'b0);
      chk("width", c & b, blockData & b);
    end
    // held write enable pushes once per free-running tick, three in all
    apb(1'b1, OFF_CTRL, 32'h0000_FC83);
    d = $urandom;
    row(0, d, 1'b1, 1'b0);
    apb(1'b0, OFF_STAT, '0);
    chk("fifocount", 3, rd[11:0]);
    rowRdReq <= 1'b1;
    @(posedge sys_clk);
    rowRdReq <= 1'b0;
    @(posedge sys_clk);
    #1;
    chk("fifohead", d, blockData);
    chk("fifoflags", 2'b00, {fifoFull, fifoEmpty});
    apb(1'b1, OFF_CTRL, 32'h0000_FC80);
    apb(1'b1, OFF_TABLE, 32'h1);
    rd = 32'h1;
    for (int i = 0; i < 200 && rd[0] !== 1'b0; i++) begin
      apb(1'b0, OFF_TABLE, '0);
    end
    chk("loaded", 0, rd[0]);
    apb(1'b1, OFF_CTRL, 32'h0000_FC81);
    repeat (6) begin
      a = $urandom % 16;
      b = $urandom % 16;
      row(a * 16 + b, 8'hFF, 1'b1, 1'b0);
      chk("product", a * b, blockData);
    end
    close_out();
  end
endmodule : tb_top
